/* rmsp_port.sv */
// RS-485 MODBUS RTU slave port: character engine, framing and request execution
// Function
// R1 - Transmit only in reply to addressed requests
// R2 - Broadcast executed, never answered
// R3 - Compare full address range up to 247
// R4 - RTU framing with CRC over RS-485 line
// R5 - Release line driver within 2 ms
// R6 - Bit rate selectable 1200 to 115200
// R7 - Eight data bits, one stop, parity option
// R8 - Start reply within 100 ms
// R9 - Speed, parity, station settings govern port
// R10 - Exactly eight selectable line speeds
// R11 - Station address valid from 1 to 247
// R12 - Address 0 broadcast; functions 03/06/05
// R13 - Drop frames with parity/stop/CRC errors
`timescale 1ns/1ns
module rmsp_port
(
   input wire logic i_clk,
   input wire logic i_srst,
   input rmsp_pkg::rmsp_cfg_t i_cfg,
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_line_oe_n,
   output logic o_wr_valid,
   output rmsp_pkg::rmsp_acc_t o_wr,
   output logic o_coil_valid,
   output rmsp_pkg::rmsp_acc_t o_coil,
   output logic o_rd_en,
   output logic [15:0] o_rd_addr,
   input wire logic [15:0] i_rd_data
);
   import rmsp_pkg::*;

   typedef enum logic [3:0]
   {
      ST_RX = 4'b0001,
      ST_EXEC = 4'b0010,
      ST_FETCH = 4'b0100,
      ST_TX = 4'b1000
   } rmsp_state_t;

   rmsp_state_t state;
   logic [15:0] bit_cyc;
   logic [19:0] gap_lim;
   logic par_en;
   logic par_odd;
   logic rx_s1;
   logic rx_s2;
   logic rx_d;
   logic rx_listen;
   logic rx_busy;
   logic [15:0] rx_cnt;
   logic [3:0] rx_bit;
   logic [10:0] rx_sh;
   logic byte_done;
   logic [7:0] rx_data;
   logic rx_bad;
   logic [3:0] rx_len;
   logic [15:0] rx_crc;
   logic rx_err;
   logic [7:0] rx_buf [0:7];
   logic [19:0] gap;
   logic frame_end;
   logic addr_hit;
   logic bcast;
   logic frame_ok;
   logic [7:0] fn;
   logic [15:0] reg_addr;
   logic [15:0] reg_val;
   logic rd_ok;
   logic wr_ok;
   logic coil_ok;
   logic fn_known;
   logic [7:0] tx_buf [0:TX_DEPTH-1];
   logic [3:0] tx_len;
   logic [3:0] tx_idx;
   logic [15:0] crc_tx;
   logic [7:0] tx_byte;
   logic [7:0] tx_data;
   logic tx_go;
   logic tx_busy;
   logic [15:0] tx_cnt;
   logic [3:0] tx_bits;
   logic [10:0] tx_sh;
   logic [1:0] fetch_ph;
   logic [1:0] word_i;
   logic [3:0] word_pos;

   // Settings act directly on framing and matching
   assign bit_cyc = rmsp_bit_cycles(i_cfg.line_speed_select); // [R6] [R9] [R10]
   assign gap_lim = 20'(bit_cyc * GAP_BITS); // [R4]
   assign par_en = (i_cfg.parity_select == PAR_EVEN) || (i_cfg.parity_select == PAR_ODD); // [R7] [R9]
   assign par_odd = (i_cfg.parity_select == PAR_ODD);
   assign rx_listen = (state == ST_RX);

   // Two-stage synchroniser on the line input
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_d <= 1'b1;
      end
      else
      begin
         rx_s1 <= i_rxd;
         rx_s2 <= rx_s1;
         rx_d <= rx_s2;
      end
   end

   // Receiver: sample at bit centres; half duplex, deaf while replying
   always_ff @(posedge i_clk)
   begin
      byte_done <= 1'b0;
      if (i_srst)
      begin
         rx_busy <= 1'b0;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_sh <= '1;
      end
      else if (!rx_busy)
      begin
         if (rx_listen && rx_d && !rx_s2)
         begin
            rx_busy <= 1'b1;
            rx_cnt <= bit_cyc >> 1;
            rx_bit <= '0;
         end
      end
      else if (rx_cnt == '0)
      begin
         rx_cnt <= bit_cyc - 16'h0001;
         rx_bit <= rx_bit + 4'h1;
         rx_sh <= {rx_s2, rx_sh[10:1]};
         if (rx_bit == (par_en ? BITS_PAR : BITS_NOPAR) - 4'h1) // [R7]
         begin
            rx_busy <= 1'b0;
            byte_done <= 1'b1;
         end
      end
      else
      begin
         rx_cnt <= rx_cnt - 16'h0001;
      end
   end

   // Without parity the character sits one place higher
   assign rx_data = par_en ? rx_sh[8:1] : rx_sh[9:2];
   assign rx_bad = !rx_sh[10] // [R13]
      || (par_en ? rx_sh[0] : rx_sh[1])
      || (par_en && ((^{rx_data, rx_sh[9]}) != par_odd)); // [R7] [R13]

   // Frame collection; overlong frames saturate and are dropped
   always_ff @(posedge i_clk)
   begin
      if (i_srst || frame_end)
      begin
         rx_len <= '0;
         rx_crc <= CRC_INIT;
         rx_err <= 1'b0;
      end
      else if (byte_done)
      begin
         if (rx_len < RX_LEN)
         begin
            rx_buf[rx_len[2:0]] <= rx_data;
         end
         if (rx_len != RX_OVER)
         begin
            rx_len <= rx_len + 4'h1;
         end
         rx_crc <= rmsp_crc_upd(rx_crc, rx_data); // [R4]
         if (rx_bad)
         begin
            rx_err <= 1'b1; // [R13]
         end
      end
   end

   // Line silence ends a frame
   always_ff @(posedge i_clk)
   begin
      if (i_srst || rx_busy || !rx_listen)
      begin
         gap <= '0;
      end
      else if (gap != gap_lim)
      begin
         gap <= gap + 20'h00001;
      end
   end

   assign frame_end = rx_listen && !rx_busy && (rx_len != '0) && (gap == gap_lim - 20'h00001); // [R4]
   assign bcast = (rx_buf[0] == ADDR_BCAST); // [R12]
   assign addr_hit = bcast || ((rx_buf[0] == i_cfg.station) // [R3] [R9]
      && (i_cfg.station >= ADDR_MIN) && (i_cfg.station <= ADDR_MAX)); // [R11]
   // Residue of zero means the trailing checksum matched
   assign frame_ok = !rx_err && (rx_len == RX_LEN) && (rx_crc == 16'h0000) && addr_hit; // [R13] [R4]

   assign fn = rx_buf[1];
   assign reg_addr = {rx_buf[2], rx_buf[3]};
   assign reg_val = {rx_buf[4], rx_buf[5]};
   assign rd_ok = (fn == FN_RD) && (reg_val != 16'h0000) && (reg_val <= QMAX); // [R12]
   assign wr_ok = (fn == FN_WR); // [R12]
   assign coil_ok = (fn == FN_COIL) && ((reg_val == COIL_ON) || (reg_val == COIL_OFF)); // [R12]
   assign fn_known = (fn == FN_RD) || (fn == FN_COIL);
   assign word_pos = {1'b0, word_i, 1'b0} + RD_HDR_LEN;
   assign tx_byte = (tx_idx < tx_len) ? tx_buf[tx_idx] : ((tx_idx == tx_len) ? crc_tx[7:0] : crc_tx[15:8]);

   // Request execution and reply sequencing; reply starts a few cycles after frame end
   always_ff @(posedge i_clk)
   begin
      o_wr_valid <= 1'b0;
      o_coil_valid <= 1'b0;
      o_rd_en <= 1'b0;
      tx_go <= 1'b0;
      if (i_srst)
      begin
         state <= ST_RX;
         o_line_oe_n <= 1'b1;
         o_wr <= '0;
         o_coil <= '0;
         o_rd_addr <= '0;
         tx_len <= '0;
         tx_idx <= '0;
         tx_data <= 8'hFF;
         crc_tx <= CRC_INIT;
         fetch_ph <= '0;
         word_i <= '0;
      end
      else
      begin
         unique case (state)
            ST_RX:
            begin
               if (frame_end && frame_ok)
               begin
                  state <= ST_EXEC; // [R1]
               end
            end
            ST_EXEC:
            begin
               tx_idx <= '0;
               crc_tx <= CRC_INIT;
               word_i <= '0;
               fetch_ph <= '0;
               if (wr_ok)
               begin
                  o_wr_valid <= 1'b1; // [R2] [R12]
                  o_wr <= {reg_addr, reg_val};
               end
               if (coil_ok)
               begin
                  o_coil_valid <= 1'b1; // [R2] [R12]
                  o_coil <= {reg_addr, reg_val};
               end
               for (int i = 0; i < 6; i++)
               begin
                  tx_buf[i] <= rx_buf[i];
               end
               tx_len <= ECHO_LEN;
               if (rd_ok)
               begin
                  tx_buf[2] <= {reg_val[6:0], 1'b0};
                  tx_len <= RD_HDR_LEN + {reg_val[2:0], 1'b0};
               end
               else if (!wr_ok && !coil_ok)
               begin
                  tx_buf[1] <= fn | FN_EXC;
                  tx_buf[2] <= fn_known ? EXC_VAL : EXC_FUNC;
                  tx_len <= EXC_LEN;
               end
               if (bcast)
               begin
                  state <= ST_RX; // [R2]
               end
               else if (rd_ok)
               begin
                  state <= ST_FETCH;
               end
               else
               begin
                  state <= ST_TX; // [R8]
                  o_line_oe_n <= 1'b0;
               end
            end
            ST_FETCH:
            begin
               // Fixed read latency: data is taken two cycles after the strobe
               unique case (fetch_ph)
                  2'h0:
                  begin
                     o_rd_en <= 1'b1;
                     o_rd_addr <= reg_addr + {14'h0000, word_i};
                     fetch_ph <= 2'h1;
                  end
                  2'h1:
                  begin
                     fetch_ph <= 2'h2;
                  end
                  default:
                  begin
                     tx_buf[word_pos] <= i_rd_data[15:8];
                     tx_buf[word_pos + 4'h1] <= i_rd_data[7:0];
                     word_i <= word_i + 2'h1;
                     fetch_ph <= 2'h0;
                     if ({14'h0000, word_i} == reg_val - 16'h0001)
                     begin
                        state <= ST_TX; // [R8]
                        o_line_oe_n <= 1'b0;
                     end
                  end
               endcase
            end
            ST_TX:
            begin
               if (!tx_busy && !tx_go)
               begin
                  if (tx_idx == tx_len + CRC_BYTES)
                  begin
                     state <= ST_RX;
                     o_line_oe_n <= 1'b1; // [R5]
                  end
                  else
                  begin
                     tx_go <= 1'b1;
                     tx_data <= tx_byte;
                     tx_idx <= tx_idx + 4'h1;
                     if (tx_idx < tx_len)
                     begin
                        crc_tx <= rmsp_crc_upd(crc_tx, tx_byte); // [R4]
                     end
                  end
               end
            end
         endcase
      end
   end

   // Transmitter; stop bit padded high when parity is off
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         tx_busy <= 1'b0;
         tx_sh <= '1;
         tx_cnt <= '0;
         tx_bits <= '0;
      end
      else if (tx_go)
      begin
         tx_busy <= 1'b1;
         tx_sh <= {1'b1, par_en ? ((^tx_data) ^ par_odd) : 1'b1, tx_data, 1'b0}; // [R7]
         tx_cnt <= bit_cyc - 16'h0001; // [R6]
         tx_bits <= par_en ? BITS_PAR : BITS_NOPAR;
      end
      else if (tx_busy)
      begin
         if (tx_cnt == '0)
         begin
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_cnt <= bit_cyc - 16'h0001;
            tx_bits <= tx_bits - 4'h1;
            if (tx_bits == 4'h1)
            begin
               tx_busy <= 1'b0;
            end
         end
         else
         begin
            tx_cnt <= tx_cnt - 16'h0001;
         end
      end
   end

   assign o_txd = tx_sh[0];
endmodule : rmsp_port

/* rmsp_pkg.sv */
// Constants, types and helpers of the RS-485 MODBUS RTU slave port
package rmsp_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int RESP_MAX_MS = 100;
   localparam int RESP_MAX_CYC = CLK_HZ / 1000 * RESP_MAX_MS;
   localparam int RELEASE_MAX_MS = 2;
   localparam int RELEASE_MAX_CYC = CLK_HZ / 1000 * RELEASE_MAX_MS;
   localparam int GAP_BITS = 39;
   localparam logic [3:0] RX_LEN = 4'h8;
   localparam logic [3:0] RX_OVER = 4'h9;
   localparam logic [15:0] QMAX = 16'h0004;
   localparam int TX_DEPTH = 16;
   localparam logic [3:0] ECHO_LEN = 4'h6;
   localparam logic [3:0] EXC_LEN = 4'h3;
   localparam logic [3:0] RD_HDR_LEN = 4'h3;
   localparam logic [3:0] CRC_BYTES = 4'h2;
   localparam logic [3:0] BITS_PAR = 4'hB;
   localparam logic [3:0] BITS_NOPAR = 4'hA;
   localparam logic [7:0] ADDR_BCAST = 8'h00;
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hF7;
   localparam logic [7:0] FN_RD = 8'h03;
   localparam logic [7:0] FN_WR = 8'h06;
   localparam logic [7:0] FN_COIL = 8'h05;
   localparam logic [7:0] FN_EXC = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_VAL = 8'h03;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;

   typedef struct packed {
      logic [2:0] line_speed_select;
      logic [1:0] parity_select;
      logic [7:0] station;
   } rmsp_cfg_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } rmsp_acc_t;

   // Clock cycles per bit, rounded to nearest
   function automatic logic [15:0] rmsp_bit_cycles(input logic [2:0] sel);
      int baud;
      unique case (sel)
         3'h0: baud = 1200;
         3'h1: baud = 2400;
         3'h2: baud = 4800;
         3'h3: baud = 9600;
         3'h4: baud = 19200;
         3'h5: baud = 38400;
         3'h6: baud = 57600;
         3'h7: baud = 115200;
      endcase
      return 16'((CLK_HZ + baud / 2) / baud);
   endfunction : rmsp_bit_cycles

   function automatic logic [15:0] rmsp_crc_upd(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : rmsp_crc_upd
endpackage : rmsp_pkg

/* rmsp_port_sva.sv */
// Assertion checker for the RS-485 MODBUS RTU slave port
`timescale 1ns/1ns
module rmsp_port_sva
import rmsp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input rmsp_pkg::rmsp_cfg_t i_cfg,
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_line_oe_n,
   input wire logic o_wr_valid,
   input rmsp_pkg::rmsp_acc_t o_wr,
   input wire logic o_coil_valid,
   input rmsp_pkg::rmsp_acc_t o_coil,
   input wire logic o_rd_en,
   input wire logic [15:0] o_rd_addr,
   input wire logic [15:0] i_rd_data
);
   logic [31:0] hi_cnt;

   // Idle-high time while driving; a stuck driver shows as a long mark
   always_ff @(posedge i_clk)
   begin
      if (i_srst || o_line_oe_n || !o_txd)
         hi_cnt <= 32'h0;
      else
         hi_cnt <= hi_cnt + 32'h1;
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_start_bit;
      ##[1:8] !o_txd;
   endsequence
   sequence s_rd_gap;
      !o_rd_en ##1 !o_rd_en;
   endsequence

   AST_TXD_IDLE: assert property (o_line_oe_n |-> o_txd)
      else $error("txd active with driver off");
   AST_START_BIT: assert property ($fell(o_line_oe_n) |-> s_start_bit)
      else $error("no start bit after driver on");
   AST_OE_HOLD: assert property ($fell(o_line_oe_n) |=> !o_line_oe_n [*8])
      else $error("driver dropped early");
   AST_RELEASE: assert property (hi_cnt < RELEASE_MAX_CYC)
      else $error("driver held too long");
   // Driver turns on in the same edge as the pulse, so look one cycle back
   AST_WR_QUIET: assert property (o_wr_valid |-> $past(o_line_oe_n))
      else $error("write while transmitting");
   AST_WR_HOLD: assert property (!o_wr_valid && !$past(i_srst) |-> $stable(o_wr))
      else $error("write data moved without pulse");
   AST_COIL_VAL: assert property (o_coil_valid |-> (o_coil.data == COIL_ON || o_coil.data == COIL_OFF))
      else $error("bad coil value");
   AST_RD_GAP: assert property (o_rd_en |=> s_rd_gap)
      else $error("read strobes too close");
   AST_RD_STEP: assert property (o_rd_en ##3 o_rd_en |-> o_rd_addr == $past(o_rd_addr, 3) + 16'h0001)
      else $error("read address not stepping");
endmodule : rmsp_port_sva

bind rmsp_port rmsp_port_sva rmsp_port_sva_inst (.i_clk(i_clk), .i_srst(i_srst), .i_cfg(i_cfg), .i_rxd(i_rxd),
   .o_txd(o_txd), .o_line_oe_n(o_line_oe_n), .o_wr_valid(o_wr_valid), .o_wr(o_wr), .o_coil_valid(o_coil_valid),
   .o_coil(o_coil), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr), .i_rd_data(i_rd_data));

/* rmsp_host.sv */
// MODBUS master model on the far side of the line
`timescale 1ns/1ns
module rmsp_host
(
   input wire logic i_clk,
   input wire logic i_txd,
   input wire logic i_oe_n,
   output logic o_rxd
);
   int bitc = 174;
   logic [1:0] par = 2'h0;
   logic [7:0] rx_q[$];
   logic [7:0] rx_b;

   initial o_rxd = 1'b1;

   // Own reference, kept apart from the port's helper
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++)
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      return c;
   endfunction : crc16

   task automatic put_bit(input logic v);
      o_rxd = v;
      repeat (bitc) @(posedge i_clk);
      #1;
   endtask : put_bit

   task automatic send_frame(input logic [7:0] q[$]);
      logic [15:0] c;
      c = crc16(q);
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      foreach (q[i])
      begin
         put_bit(1'b0);
         for (int k = 0; k < 8; k++)
            put_bit(q[i][k]);
         if (par != 2'h0)
            put_bit((par == 2'h1) ? ^q[i] : ~^q[i]);
         put_bit(1'b1);
      end
   endtask : send_frame

   // Mid-bit sampling, only while the port drives
   always
   begin
      @(negedge i_txd);
      if (!i_oe_n)
      begin
         repeat (bitc / 2) @(posedge i_clk);
         for (int k = 0; k < 8; k++)
         begin
            repeat (bitc) @(posedge i_clk);
            rx_b[k] = i_txd;
         end
         rx_q.push_back(rx_b);
         repeat ((par != 2'h0) ? 2 * bitc : bitc) @(posedge i_clk);
      end
   end
endmodule : rmsp_host

/* test_rs485_modbus_rtu_slave_port.sv */
// Testbench of the RS-485 MODBUS RTU slave port
`timescale 1ns/1ns
module test_rs485_modbus_rtu_slave_port;
   import rmsp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   rmsp_cfg_t cfg = '{3'h7, PAR_NONE, ADDR_MAX};
   logic rxd, txd, oe_n, wr_valid, coil_valid, rd_en;
   rmsp_acc_t wr, coil, got_wr, got_coil;
   logic [15:0] rd_addr;
   logic [15:0] last_rd;
   logic [15:0] rd_data = 16'h0000;
   int num_errors = 0;
   int samples_checked = 0;
   int n_wr, n_coil, n_rd;
   int bitc = (CLK_HZ + 57600) / 115200;

   always #25 clk = ~clk;
   always @(posedge clk)
      if (rd_en)
         rd_data <= #1 rd_addr ^ 16'h5A5A;

   rmsp_port rmsp_port_inst (.i_clk(clk), .i_srst(srst), .i_cfg(cfg), .i_rxd(rxd), .o_txd(txd),
      .o_line_oe_n(oe_n), .o_wr_valid(wr_valid), .o_wr(wr), .o_coil_valid(coil_valid), .o_coil(coil),
      .o_rd_en(rd_en), .o_rd_addr(rd_addr), .i_rd_data(rd_data));
   rmsp_host rmsp_host_inst (.i_clk(clk), .i_txd(txd), .i_oe_n(oe_n), .o_rxd(rxd));

   task automatic end_sim();
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: %s", $time, msg);
         num_errors++;
      end
   endtask : chk

   // Sends a request, watches pulses and the reply; exp gets its CRC here
   task automatic transact(input logic [7:0] req[$], input logic [7:0] exp[$]);
      int lim;
      logic [15:0] c;
      logic seen;
      lim = (exp.size() == 0) ? 45 * bitc : 200 * bitc;
      seen = 1'b0;
      n_wr = 0;
      n_coil = 0;
      n_rd = 0;
      if (exp.size() != 0)
      begin
         c = rmsp_host_inst.crc16(exp);
         exp.push_back(c[7:0]);
         exp.push_back(c[15:8]);
      end
      rmsp_host_inst.rx_q.delete();
      rmsp_host_inst.send_frame(req);
      for (int t = 0; t < lim; t++)
      begin
         @(posedge clk);
         #1;
         if (wr_valid)
         begin
            n_wr++;
            got_wr = wr;
         end
         if (coil_valid)
         begin
            n_coil++;
            got_coil = coil;
         end
         if (rd_en)
         begin
            n_rd++;
            last_rd = rd_addr;
         end
         if (!oe_n && !seen)
         begin
            seen = 1'b1;
            chk(32'(t < RESP_MAX_CYC), 32'h1, "reply start late");
         end
         if (seen && oe_n)
            break;
      end
      if (exp.size() != 0 && !(seen && oe_n))
      begin
         $display("CHECK FAILED at %0t: reply timeout", $time);
         num_errors++;
      end
      // A cut reply may leave rx_q empty, so the driver enable is judged as well
      chk(32'(seen), 32'(exp.size() != 0), "driver enable use");
      chk(32'(rmsp_host_inst.rx_q.size()), 32'(exp.size()), "reply length");
      foreach (exp[i])
         if (i < rmsp_host_inst.rx_q.size())
            chk(rmsp_host_inst.rx_q[i], exp[i], "reply byte");
   endtask : transact

   task automatic sc_write();
      logic [7:0] q[$];
      q = {ADDR_MAX, FN_WR, 8'h00, 8'h0A, 8'h12, 8'h34};
      transact(q, q);
      chk(n_wr, 1, "write pulses");
      chk(got_wr, {16'h000A, 16'h1234}, "write data");
   endtask : sc_write

   task automatic sc_bcast();
      logic [7:0] q[$];
      logic [7:0] e[$];
      q = {ADDR_BCAST, FN_COIL, 8'h00, 8'h03, 8'hFF, 8'h00};
      transact(q, e);
      chk(n_coil, 1, "coil pulses");
      chk(got_coil, {16'h0003, COIL_ON}, "coil data");
   endtask : sc_bcast

   task automatic sc_read();
      logic [7:0] q[$];
      logic [7:0] e[$];
      cfg = '{3'h7, PAR_EVEN, ADDR_MIN};
      rmsp_host_inst.par = PAR_EVEN;
      q = {ADDR_MIN, FN_RD, 8'h00, 8'h10, 8'h00, 8'h02};
      e = {ADDR_MIN, FN_RD, 8'h04, 8'h5A, 8'h4A, 8'h5A, 8'h4B};
      transact(q, e);
      chk(n_rd, 2, "read strobes");
      chk(last_rd, 16'h0011, "last read address");
   endtask : sc_read

   initial
   begin
      rmsp_host_inst.bitc = bitc;
      repeat (10) @(posedge clk);
      #1;
      srst = 1'b0;
      // Synchroniser already holds idle; keeps the run short
      repeat (4) @(posedge clk);
      #1;
      sc_write();
      sc_bcast();
      sc_read();
      end_sim();
   end
endmodule : test_rs485_modbus_rtu_slave_port
